/* rtl/periodic_timer_consts.svh */
// register offsets, field positions, reset values and clock ratios of the periodic timer
`ifndef PERIODIC_TIMER_CONSTS_SVH
`define PERIODIC_TIMER_CONSTS_SVH
`define OFS_CONTROL_0 12'h000
`define OFS_CONTROL_1 12'h004
`define OFS_CONTROL_2 12'h008
`define OFS_COUNTER_LOW 12'h00C
`define OFS_COUNTER_HIGH 12'h010
`define OFS_COMPARE_A_LOW 12'h014
`define OFS_COMPARE_A_HIGH 12'h018
`define OFS_CAPTURE_B_LOW 12'h01C
`define OFS_CAPTURE_B_HIGH 12'h020
`define OFS_PERIOD_LOW 12'h024
`define OFS_PERIOD_HIGH 12'h028
`define OFS_IRQ_FLAGS 12'h02C
`define CONTROL_0_RESET 8'h00
`define CONTROL_1_RESET 8'h00
`define CONTROL_0_MASK 8'hF8
`define BIT_HOLD 7
`define BIT_RUN 3
`define BIT_INITIAL 3
`define BIT_INVERT 2
`define BIT_CAPSRC 1
`define BIT_CLRSEL 0
`define BIT_LATCH_EDGE 0
`define FLAG_A 0
`define FLAG_P 1
`define COUNTER_WIDTH 10
`define HIGH_CLOCK_DIV 8'd1
`define SUB_CLOCK_DIV 8'd250
`define SYS_DIV_4 8'd4
`define HIGH_DIV_16 8'd16
`define HIGH_DIV_64 8'd64
`endif

/* rtl/periodic_timer_core.sv */
// periodic timer core: 10-bit counter, comparators A and P, capture, output pin, APB registers
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "periodic_timer_consts.svh"

module periodic_timer_core (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_output_pin,
  output logic inverted_output_pin,
  output logic compareAIrq,
  output logic comparePIrq
);
  logic [7:0] control0;
  logic [7:0] control1;
  logic [2:0] control2;
  logic [9:0] counter;
  logic [9:0] compareA;
  logic [9:0] captureB;
  logic [9:0] period;
  logic [7:0] byteBuffer;
  logic [1:0] irqFlags;
  logic runDelayed;
  logic [1:0] extSync;
  logic [1:0] capSync;
  logic extLast;
  logic capLast;
  logic [7:0] prescale;
  logic pinLevel;
  periodic_timer_pkg::pulse_type pulseState;

  wire access = psel && penable;
  wire wrStrobe = access && pwrite;
  wire rdStrobe = access && !pwrite;
  wire running = control0[`BIT_RUN];
  wire runRise = running && !runDelayed;
  wire holding = control0[`BIT_HOLD];
  periodic_timer_pkg::mode_type mode;
  periodic_timer_pkg::clock_type clockSel;
  assign mode = periodic_timer_pkg::mode_type'(control1[7:6]);
  assign clockSel = periodic_timer_pkg::clock_type'(control0[6:4]);
  wire [1:0] pinFunc = control1[5:4];
  wire [1:0] capClear = control2[2:1];
  wire initialLevel = control1[`BIT_INITIAL];

  // tick generation; internal ratios come from a shared prescaler off ref_clk
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extSync <= 2'h0;
      capSync <= 2'h0;
      extLast <= 1'b0;
      capLast <= 1'b0;
    end else begin
      extSync <= {extSync[0], external_clock_pin};
      capSync <= {capSync[0], capture_input_pin};
      extLast <= extSync[1];
      capLast <= capSync[1];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale <= 8'h00;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  logic [7:0] divide;
  logic tick;
  always_comb begin
    divide = `SYS_DIV_4;
    tick = 1'b0;
    case (clockSel)
      periodic_timer_pkg::CLK_SYS_DIV4: divide = `SYS_DIV_4;
      periodic_timer_pkg::CLK_SYS: divide = 8'd1;
      periodic_timer_pkg::CLK_HIGH_DIV16: divide = `HIGH_DIV_16 * `HIGH_CLOCK_DIV;
      periodic_timer_pkg::CLK_HIGH_DIV64: divide = `HIGH_DIV_64 * `HIGH_CLOCK_DIV;
      periodic_timer_pkg::CLK_SUB_A: divide = `SUB_CLOCK_DIV;
      periodic_timer_pkg::CLK_SUB_B: divide = `SUB_CLOCK_DIV;
      default: divide = 8'd1;
    endcase
    if (clockSel == periodic_timer_pkg::CLK_PIN_RISE) begin
      tick = extSync[1] && !extLast;
    end else if (clockSel == periodic_timer_pkg::CLK_PIN_FALL) begin
      tick = !extSync[1] && extLast;
    end else begin
      // exact for power-of-two divisors only; sub clock ratio is approximate
      tick = (prescale % divide) == 8'h00;
    end
  end

  // capture source: capture pin or the external clock pin
  wire capLevel = control1[`BIT_CAPSRC] ? extSync[1] : capSync[1];
  wire capPrev = control1[`BIT_CAPSRC] ? extLast : capLast;
  wire capRise = capLevel && !capPrev;
  wire capFall = !capLevel && capPrev;

  wire advance = running && !holding && tick;
  wire matchA = advance && (counter == compareA);
  wire matchP = advance && (counter == period);
  wire overflow = advance && (counter == 10'h3FF);
  wire isCapture = (mode == periodic_timer_pkg::MODE_CAPTURE);

  logic clearCount;
  always_comb begin
    clearCount = 1'b0;
    if (isCapture) begin
      clearCount = matchP
        || (advance && capClear == 2'h1 && capRise)
        || (advance && capClear == 2'h2 && capFall)
        || (advance && capClear == 2'h3 && (capRise || capFall));
    end else if (mode == periodic_timer_pkg::MODE_PWM) begin
      clearCount = matchP;
    end else if (control1[`BIT_CLRSEL]) begin
      clearCount = matchA;
    end else begin
      clearCount = (period == 10'h000) ? overflow : matchP;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter <= 10'h000;
      runDelayed <= 1'b0;
    end else begin
      runDelayed <= running;
      if (runRise) begin
        counter <= 10'h000;
      end else if (clearCount) begin
        counter <= 10'h000;
      end else if (advance) begin
        counter <= counter + 10'h001;
      end
    end
  end

  // capture edge decode
  logic capToA;
  logic capToB;
  always_comb begin
    capToA = 1'b0;
    capToB = 1'b0;
    if (isCapture && running) begin
      if (capClear == 2'h0) begin
        case (pinFunc)
          2'h0: capToA = capRise;
          2'h1: capToA = capFall;
          2'h2: capToA = capRise || capFall;
          default: capToA = 1'b0;
        endcase
      end else begin
        case (pinFunc)
          2'h0: capToB = capRise;
          2'h1: capToA = capFall;
          2'h2: begin
            capToA = capFall;
            capToB = capRise;
          end
          default: capToA = 1'b0;
        endcase
      end
    end
  end

  // register writes; high byte commits the buffered low byte
  wire [11:0] addr = paddr;
  wire wrHighA = wrStrobe && addr == `OFS_COMPARE_A_HIGH;
  wire wrHighB = wrStrobe && addr == `OFS_CAPTURE_B_HIGH;
  wire wrHighP = wrStrobe && addr == `OFS_PERIOD_HIGH;
  wire wrLow = wrStrobe && (addr == `OFS_COMPARE_A_LOW || addr == `OFS_CAPTURE_B_LOW
    || addr == `OFS_PERIOD_LOW);
  wire rdHigh = rdStrobe && (addr == `OFS_COUNTER_HIGH || addr == `OFS_COMPARE_A_HIGH
    || addr == `OFS_CAPTURE_B_HIGH || addr == `OFS_PERIOD_HIGH);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      control0 <= `CONTROL_0_RESET;
      control1 <= `CONTROL_1_RESET;
      control2 <= 3'h0;
    end else begin
      if (wrStrobe && addr == `OFS_CONTROL_0) begin
        control0 <= pwdata[7:0] & `CONTROL_0_MASK;
      end
      if (wrStrobe && addr == `OFS_CONTROL_1) begin
        control1 <= pwdata[7:0];
      end
      if (wrStrobe && addr == `OFS_CONTROL_2) begin
        control2[2:1] <= pwdata[2:1];
      end
      // latch edge flag records the polarity of the last rise or fall while a clear edge is selected, clearing or not
      if (isCapture && advance && capClear != 2'h0 && (capRise || capFall)) begin
        control2[`BIT_LATCH_EDGE] <= capRise;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byteBuffer <= 8'h00;
    end else if (wrLow) begin
      byteBuffer <= pwdata[7:0];
    end else if (rdHigh) begin
      case (addr)
        `OFS_COUNTER_HIGH: byteBuffer <= counter[7:0];
        `OFS_COMPARE_A_HIGH: byteBuffer <= compareA[7:0];
        `OFS_CAPTURE_B_HIGH: byteBuffer <= captureB[7:0];
        default: byteBuffer <= period[7:0];
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compareA <= 10'h000;
    end else if (capToA) begin
      compareA <= counter;
    end else if (wrHighA) begin
      compareA <= {pwdata[1:0], byteBuffer};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      captureB <= 10'h000;
    end else if (capToB) begin
      captureB <= counter;
    end else if (wrHighB) begin
      captureB <= {pwdata[1:0], byteBuffer};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      period <= 10'h000;
    end else if (wrHighP) begin
      period <= {pwdata[1:0], byteBuffer};
    end
  end

  // sticky flags; a match in the clearing cycle wins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqFlags <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `FLAG_A) ? matchA : matchP) begin
          irqFlags[i] <= 1'b1;
        end else if (wrStrobe && addr == `OFS_IRQ_FLAGS && pwdata[i]) begin
          irqFlags[i] <= 1'b0;
        end
      end
    end
  end

  // single pulse: starts on run rise, ends on A match or run clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseState <= periodic_timer_pkg::PULSE_IDLE;
    end else begin
      case (pulseState)
        periodic_timer_pkg::PULSE_IDLE: begin
          if (runRise) begin
            pulseState <= periodic_timer_pkg::PULSE_ACTIVE;
          end
        end
        periodic_timer_pkg::PULSE_ACTIVE: begin
          if (matchA || !running) begin
            pulseState <= periodic_timer_pkg::PULSE_DONE;
          end
        end
        periodic_timer_pkg::PULSE_DONE: begin
          if (runRise) begin
            pulseState <= periodic_timer_pkg::PULSE_ACTIVE;
          end
        end
        default: pulseState <= periodic_timer_pkg::PULSE_IDLE;
      endcase
    end
  end

  // pwm: active from period start until A match
  logic pwmActive;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwmActive <= 1'b0;
    end else if (runRise || matchP) begin
      pwmActive <= 1'b1;
    end else if (matchA) begin
      pwmActive <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinLevel <= 1'b0;
    end else begin
      case (mode)
        periodic_timer_pkg::MODE_COMPARE: begin
          if (runRise) begin
            pinLevel <= initialLevel;
          end else if (matchA) begin
            case (pinFunc)
              2'h1: pinLevel <= 1'b0;
              2'h2: pinLevel <= 1'b1;
              2'h3: pinLevel <= !pinLevel;
              default: pinLevel <= pinLevel;
            endcase
          end
        end
        periodic_timer_pkg::MODE_PWM: begin
          // run rise restarts both waveforms at the active level
          if (runRise) begin
            pinLevel <= initialLevel;
          end else begin
            case (pinFunc)
              2'h0: pinLevel <= !initialLevel;
              2'h1: pinLevel <= initialLevel;
              2'h2: pinLevel <= pwmActive ? initialLevel : !initialLevel;
              default: pinLevel <= (pulseState == periodic_timer_pkg::PULSE_ACTIVE) ? initialLevel : !initialLevel;
            endcase
          end
        end
        default: pinLevel <= pinLevel;
      endcase
    end
  end

  // polarity applies outside timer mode only
  assign timer_output_pin = pinLevel ^ (control1[`BIT_INVERT] && mode != periodic_timer_pkg::MODE_TIMER);
  assign inverted_output_pin = !timer_output_pin;
  assign compareAIrq = irqFlags[`FLAG_A];
  assign comparePIrq = irqFlags[`FLAG_P];

  // apb slave: zero wait states, unmapped addresses read zero with pslverr
  logic mapped;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (addr)
      `OFS_CONTROL_0: prdata = {24'h0, control0};
      `OFS_CONTROL_1: prdata = {24'h0, control1};
      `OFS_CONTROL_2: prdata = {29'h0, control2};
      `OFS_COUNTER_LOW, `OFS_COMPARE_A_LOW, `OFS_CAPTURE_B_LOW, `OFS_PERIOD_LOW:
        prdata = {24'h0, byteBuffer};
      `OFS_COUNTER_HIGH: prdata = {30'h0, counter[9:8]};
      `OFS_COMPARE_A_HIGH: prdata = {30'h0, compareA[9:8]};
      `OFS_CAPTURE_B_HIGH: prdata = {30'h0, captureB[9:8]};
      `OFS_PERIOD_HIGH: prdata = {30'h0, period[9:8]};
      `OFS_IRQ_FLAGS: prdata = {30'h0, irqFlags};
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
endmodule

/* rtl/periodic_timer_pkg.sv */
// types of the periodic timer
package periodic_timer_pkg;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } mode_type;
  typedef enum logic [2:0] {
    CLK_SYS_DIV4 = 3'h0,
    CLK_SYS = 3'h1,
    CLK_HIGH_DIV16 = 3'h2,
    CLK_HIGH_DIV64 = 3'h3,
    CLK_SUB_A = 3'h4,
    CLK_SUB_B = 3'h5,
    CLK_PIN_RISE = 3'h6,
    CLK_PIN_FALL = 3'h7
  } clock_type;
  typedef enum logic [2:0] {
    PULSE_IDLE = 3'b001,
    PULSE_ACTIVE = 3'b010,
    PULSE_DONE = 3'b100
  } pulse_type;
endpackage

/* test/far_pins_model.sv */
// far-side model: external clock pulse train and capture input level
`timescale 1ns/1ps
module far_pins_model (
  input wire logic ref_clk,
  input wire logic [3:0] pulseCount,
  input wire logic pulseGo,
  input wire logic captureLevel,
  output logic external_clock_pin,
  output logic capture_input_pin
);
  logic [6:0] phase = 7'h00;
  logic pinLevel = 1'h0;
  assign capture_input_pin = captureLevel;
  assign external_clock_pin = pinLevel;
  // 4 high, 4 low per pulse: slow enough for the 2-flop synchroniser; idle low between frames
  always @(posedge ref_clk) begin
    if (pulseGo) begin
      phase <= {pulseCount, 3'h0};
    end else if (phase != 7'h00) begin
      phase <= phase - 7'h01;
    end
    pinLevel <= (phase != 7'h00) && phase[2];
  end
endmodule

/* test/periodic_timer_core_asserts.sv */
// concurrent checks on the periodic timer ports
`timescale 1ns/1ps
`include "periodic_timer_consts.svh"
module periodic_timer_core_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  input wire logic timer_output_pin,
  input wire logic inverted_output_pin,
  input wire logic compareAIrq,
  input wire logic comparePIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic rdAcc, clrA, clrP;
  assign rdAcc = psel && penable && !pwrite;
  assign clrA = psel && penable && pwrite && paddr == `OFS_IRQ_FLAGS && pwdata[0];
  assign clrP = psel && penable && pwrite && paddr == `OFS_IRQ_FLAGS && pwdata[1];
  chk_inv_pin: assert property (inverted_output_pin == !timer_output_pin)
    else $error("inverted pin not inverse of timer pin");
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_unmapped_read: assert property (rdAcc && paddr > `OFS_IRQ_FLAGS |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_counter_high: assert property (rdAcc && paddr == `OFS_COUNTER_HIGH |-> prdata[31:2] == 30'h0)
    else $error("counter high byte wider than two bits");
  chk_ctrl0_unused: assert property (rdAcc && paddr == `OFS_CONTROL_0 |-> prdata[2:0] == 3'h0)
    else $error("unused control bits not zero");
  chk_flag_a_hold: assert property (compareAIrq && !clrA |=> compareAIrq)
    else $error("flag A dropped without clear");
  chk_flag_p_hold: assert property (comparePIrq && !clrP |=> comparePIrq)
    else $error("flag P dropped without clear");
  chk_flag_read: assert property (rdAcc && paddr == `OFS_IRQ_FLAGS |-> prdata[1:0] == {comparePIrq, compareAIrq})
    else $error("flag register read mismatch");
  cover property ($rose(compareAIrq));
  cover property ($rose(comparePIrq));
  cover property (pslverr);
endmodule
bind periodic_timer_core periodic_timer_core_asserts u_periodic_timer_core_asserts (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_clock_pin(external_clock_pin), .capture_input_pin(capture_input_pin),
  .timer_output_pin(timer_output_pin), .inverted_output_pin(inverted_output_pin),
  .compareAIrq(compareAIrq), .comparePIrq(comparePIrq)
);

/* test/periodic_timer_core_bench.sv */
// self-checking bench for the periodic timer core
`timescale 1ns/1ps
`include "periodic_timer_consts.svh"
module periodic_timer_core_bench;
  typedef struct packed {logic wr; logic [11:0] addr; logic [7:0] data; logic err;} row_type;
  logic ref_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, cnt, held;
  logic pready, pslverr, err, extPin, capPin, outPin, outPinN, irqA, irqP;
  logic pulseGo = 1'h0, capLevel = 1'h0;
  logic [3:0] pulseCount = 4'h0;
  int failures = 0, total_checks = 0;
  int highCount = 0;
  row_type rows [0:18];
  always #2 ref_clk = ~ref_clk;
  periodic_timer_core u_periodic_timer_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_pin(extPin), .capture_input_pin(capPin), .timer_output_pin(outPin),
    .inverted_output_pin(outPinN), .compareAIrq(irqA), .comparePIrq(irqP));
  far_pins_model u_far_pins_model (.ref_clk(ref_clk), .pulseCount(pulseCount), .pulseGo(pulseGo),
    .captureLevel(capLevel), .external_clock_pin(extPin), .capture_input_pin(capPin));
  task report_and_stop;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    forever begin
      @(posedge ref_clk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // high first so the low read sees the snapshot; every low byte sits 4 below its high byte
  task read_pair(input logic [11:0] hi);
    apb(1'h0, hi, 8'h00);
    cnt = {22'h0, rd[1:0], 8'h00};
    apb(1'h0, hi - 12'h004, 8'h00);
    cnt[7:0] = rd[7:0];
  endtask
  task count_high(input int cycles);
    highCount = 0;
    repeat (cycles) begin
      @(posedge ref_clk);
      #1;
      if (outPin === 1'h1) highCount++;
    end
  endtask
  task wait_irq(input logic p);
    for (int i = 0; i < 80; i++) begin
      if ((p ? irqP : irqA) === 1'h1) break;
      @(posedge ref_clk);
      #1;
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop;
  end
  initial begin
    rows = '{'{1'h0, `OFS_CONTROL_0, 8'h00, 1'h0}, '{1'h0, `OFS_CONTROL_1, 8'h00, 1'h0},
      '{1'h1, `OFS_CONTROL_0, 8'hF7, 1'h0}, '{1'h0, `OFS_CONTROL_0, 8'hF0, 1'h0},
      '{1'h1, `OFS_CONTROL_1, 8'hA5, 1'h0}, '{1'h0, `OFS_CONTROL_1, 8'hA5, 1'h0},
      '{1'h1, `OFS_CONTROL_2, 8'h07, 1'h0}, '{1'h0, `OFS_CONTROL_2, 8'h06, 1'h0},
      '{1'h1, `OFS_PERIOD_LOW, 8'h34, 1'h0}, '{1'h1, `OFS_PERIOD_HIGH, 8'h02, 1'h0},
      '{1'h0, `OFS_PERIOD_HIGH, 8'h02, 1'h0}, '{1'h0, `OFS_PERIOD_LOW, 8'h34, 1'h0},
      '{1'h1, `OFS_COUNTER_HIGH, 8'h03, 1'h0}, '{1'h0, `OFS_COUNTER_HIGH, 8'h00, 1'h0},
      '{1'h0, 12'h030, 8'h00, 1'h1}, '{1'h1, `OFS_COMPARE_A_LOW, 8'h05, 1'h0},
      '{1'h1, `OFS_COMPARE_A_HIGH, 8'h00, 1'h0}, '{1'h0, `OFS_COMPARE_A_HIGH, 8'h00, 1'h0},
      '{1'h0, `OFS_COMPARE_A_LOW, 8'h05, 1'h0}};
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) check(rd, {24'h0, rows[i].data});
      check({31'h0, err}, {31'h0, rows[i].err});
    end
    apb(1'h1, `OFS_CONTROL_1, 8'h39);
    apb(1'h1, `OFS_CONTROL_0, 8'h18);
    wait_irq(1'h0);
    check({31'h0, irqA}, 32'h1);
    check({31'h0, outPin}, 32'h0);
    read_pair(`OFS_COUNTER_HIGH);
    check({31'h0, cnt <= 32'h5}, 32'h1);
    apb(1'h1, `OFS_CONTROL_0, 8'h98);
    read_pair(`OFS_COUNTER_HIGH);
    held = cnt;
    repeat (10) @(posedge ref_clk);
    read_pair(`OFS_COUNTER_HIGH);
    check(cnt, held);
    apb(1'h1, `OFS_CONTROL_0, 8'h90);
    apb(1'h1, `OFS_CONTROL_0, 8'h98);
    read_pair(`OFS_COUNTER_HIGH);
    check(cnt, 32'h0);
    check({31'h0, outPin}, 32'h1);
    check({31'h0, outPinN}, 32'h0);
    apb(1'h1, `OFS_IRQ_FLAGS, 8'h03);
    apb(1'h0, `OFS_IRQ_FLAGS, 8'h00);
    check(rd, 32'h0);
    apb(1'h1, `OFS_CONTROL_0, 8'h00);
    apb(1'h1, `OFS_CONTROL_1, 8'h00);
    apb(1'h1, `OFS_PERIOD_LOW, 8'h03);
    apb(1'h1, `OFS_PERIOD_HIGH, 8'h00);
    apb(1'h1, `OFS_CONTROL_0, 8'h18);
    wait_irq(1'h1);
    check({31'h0, irqP}, 32'h1);
    repeat (40) @(posedge ref_clk);
    check({31'h0, irqA}, 32'h0);
    apb(1'h1, `OFS_CONTROL_0, 8'h00);
    apb(1'h1, `OFS_PERIOD_LOW, 8'hFF);
    apb(1'h1, `OFS_PERIOD_HIGH, 8'h03);
    apb(1'h1, `OFS_CONTROL_2, 8'h00);
    apb(1'h1, `OFS_CONTROL_1, 8'h40);
    apb(1'h1, `OFS_CONTROL_0, 8'h18);
    repeat (20) @(posedge ref_clk);
    apb(1'h1, `OFS_CONTROL_0, 8'h98);
    read_pair(`OFS_COUNTER_HIGH);
    held = cnt;
    capLevel <= 1'h1;
    repeat (8) @(posedge ref_clk);
    read_pair(`OFS_COMPARE_A_HIGH);
    check(cnt, held);
    for (int s = 6; s < 8; s++) begin
      apb(1'h1, `OFS_CONTROL_0, 8'h00);
      apb(1'h1, `OFS_CONTROL_1, 8'hC0);
      apb(1'h1, `OFS_CONTROL_0, {1'h0, s[2:0], 4'h8});
      pulseCount <= 4'h5;
      pulseGo <= 1'h1;
      @(posedge ref_clk);
      pulseGo <= 1'h0;
      repeat (60) @(posedge ref_clk);
      read_pair(`OFS_COUNTER_HIGH);
      check(cnt, 32'h5);
    end
    // forced active level under inversion, then duty of A+1 ticks per P+1
    apb(1'h1, `OFS_CONTROL_0, 8'h00);
    apb(1'h1, `OFS_COMPARE_A_LOW, 8'h03);
    apb(1'h1, `OFS_COMPARE_A_HIGH, 8'h00);
    apb(1'h1, `OFS_PERIOD_LOW, 8'h07);
    apb(1'h1, `OFS_PERIOD_HIGH, 8'h00);
    apb(1'h1, `OFS_CONTROL_1, 8'h9C);
    repeat (2) @(posedge ref_clk);
    #1;
    check({31'h0, outPin}, 32'h0);
    check({31'h0, outPinN}, 32'h1);
    apb(1'h1, `OFS_CONTROL_1, 8'hA8);
    apb(1'h1, `OFS_CONTROL_0, 8'h18);
    repeat (4) @(posedge ref_clk);
    count_high(16);
    check(highCount, 32'h8);
    // single pulse: run-rise edge, counts 0 to 3, then the A match edge
    apb(1'h1, `OFS_CONTROL_0, 8'h00);
    apb(1'h1, `OFS_CONTROL_1, 8'hB8);
    apb(1'h1, `OFS_CONTROL_0, 8'h18);
    count_high(30);
    check(highCount, 32'h5);
    // split capture: rise into B and clears, fall into A; latch flag follows polarity
    apb(1'h1, `OFS_CONTROL_0, 8'h00);
    capLevel <= 1'h0;
    apb(1'h1, `OFS_PERIOD_LOW, 8'hFF);
    apb(1'h1, `OFS_PERIOD_HIGH, 8'h03);
    apb(1'h1, `OFS_CONTROL_2, 8'h02);
    apb(1'h1, `OFS_CONTROL_1, 8'h60);
    apb(1'h1, `OFS_CONTROL_0, 8'h18);
    repeat (60) @(posedge ref_clk);
    capLevel <= 1'h1;
    repeat (8) @(posedge ref_clk);
    read_pair(`OFS_CAPTURE_B_HIGH);
    check({31'h0, (cnt >= 32'h32)}, 32'h1);
    read_pair(`OFS_COUNTER_HIGH);
    check({31'h0, (cnt < 32'h1E)}, 32'h1);
    apb(1'h0, `OFS_CONTROL_2, 8'h00);
    check(rd, 32'h3);
    capLevel <= 1'h0;
    repeat (8) @(posedge ref_clk);
    read_pair(`OFS_COMPARE_A_HIGH);
    check({31'h0, (cnt > 32'h8 && cnt < 32'h3C)}, 32'h1);
    apb(1'h0, `OFS_CONTROL_2, 8'h00);
    check(rd, 32'h2);
    // quarter-rate clock: 42 edges after the clearing edge give 10 or 11 ticks
    apb(1'h1, `OFS_CONTROL_0, 8'h00);
    apb(1'h1, `OFS_CONTROL_1, 8'hC0);
    apb(1'h1, `OFS_CONTROL_0, 8'h08);
    repeat (40) @(posedge ref_clk);
    apb(1'h1, `OFS_CONTROL_0, 8'h88);
    read_pair(`OFS_COUNTER_HIGH);
    check({31'h0, (cnt >= 32'hA && cnt <= 32'hB)}, 32'h1);
    // reset in mid-run: sticky flags, control and counter return to zero
    check({31'h0, irqP}, 32'h1);
    sys_rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    check({30'h0, irqP, irqA}, 32'h0);
    check({31'h0, outPinN}, 32'h1);
    @(posedge ref_clk);
    sys_rst <= 1'h0;
    apb(1'h0, `OFS_CONTROL_0, 8'h00);
    check(rd, 32'h0);
    read_pair(`OFS_COUNTER_HIGH);
    check(cnt, 32'h0);
    report_and_stop;
  end
endmodule
